// [logic/error_code_monitor.v]
// Notes on behaviour
// - Blown encoder supply fuse loads code 35.
// - Jump or call label above 511 loads code 36.
// - Executing a sequence line above 8190 loads code 37.
// - Register index beyond its group maximum loads code 38.
// - Call stack holds 256 entries; a further push loads code 39.
// - First checked parameter out of its legal set loads code 40.
// - Second checked parameter out of its legal set loads code 41.
// - Multi-axis bus timeout loads code 56 only when bus option bit 1 set.
// - Duplicate node number on the multi-axis bus loads code 59.
// - Switch still active after leave distance during homing loads code 60.
// - Both end stops hit in multi-index homing loads code 61.
// - Both end stops hit in single-index homing loads code 62.
// - Start-on-input synchronisation failure loads code 63.
// - Limit control bit 1: measured position outside limits loads code 65.
// - Limit control bit 2: reference position outside limits loads code 66.
// - Movement request without power stage enabled is refused, code 67.
// - Power-on request in interpolation mode is refused, code 68.
// - Homing request not allowed by configuration is refused, code 69.
// - Serial host link framing error loads code 80.
// - Serial host link receive overrun loads code 81.
// - Serial host link checksum mismatch loads code 82.
// - Error code register readable, resets to 0, 0 means no error.
`include "error_code_monitor_map.vh"
`timescale 1ns/1ns
`default_nettype none

module error_code_monitor #(
	parameter POS_WIDTH = 32,
	parameter STACK_DEPTH = `STACK_DEPTH
) (
	input wire clk_in,
	input wire rst_in,
	input wire wb_cyc_in,
	input wire wb_stb_in,
	input wire wb_we_in,
	input wire [3:0] wb_adr_in,
	input wire [3:0] wb_sel_in,
	input wire [31:0] wb_dat_in,
	output reg [31:0] wb_dat_out,
	output reg wb_ack_out,
	input wire fuse_blown_in,
	input wire jump_valid_in,
	input wire [15:0] jump_label_in,
	input wire line_exec_in,
	input wire [15:0] line_number_in,
	input wire reg_access_in,
	input wire [15:0] reg_index_in,
	input wire [15:0] reg_index_max_in,
	input wire stack_push_in,
	input wire stack_pop_in,
	input wire checked_param_a_bad_in,
	input wire checked_param_b_bad_in,
	input wire bus_timeout_in,
	input wire dup_node_in,
	input wire homing_active_in,
	input wire switch_leave_done_in,
	input wire home_switch_in,
	input wire multi_index_setting_in,
	input wire end_stop_detect_a_in,
	input wire end_stop_detect_b_in,
	input wire homing_done_in,
	input wire start_on_input_sync_fail_in,
	input wire position_valid_in,
	input wire signed [POS_WIDTH-1:0] measured_position_in,
	input wire signed [POS_WIDTH-1:0] reference_position_in,
	input wire move_req_in,
	input wire power_stage_enable_in,
	input wire power_on_req_in,
	input wire interpolation_mode_in,
	input wire homing_req_in,
	input wire homing_allowed_in,
	input wire link_framing_err_in,
	input wire link_overrun_err_in,
	input wire link_checksum_err_in,
	output reg [7:0] error_code_value_out,
	output reg move_refused_out,
	output reg power_on_refused_out,
	output reg homing_refused_out,
	output reg [8:0] stack_level_out
);

	reg [7:0] bus_option_param;
	reg [7:0] limit_check_control;
	reg signed [POS_WIDTH-1:0] position_limit_low;
	reg signed [POS_WIDTH-1:0] position_limit_high;
	reg [8:0] next_stack_level;
	reg [7:0] next_code;
	reg [31:0] next_rdata;
	reg [1:0] stop_seen;
	wire [1:0] stop_now;
	wire bus_req;
	wire wr_req;
	wire rd_req;
	wire sel_code;
	wire sel_ctrl;
	wire sel_low;
	wire sel_high;
	wire wr_bus_opt;
	wire wr_limit_ctrl;
	wire wr_low;
	wire wr_high;
	wire [7:0] ctrl_lane0;
	wire [7:0] ctrl_lane1;
	wire clear_code;
	wire both_stops;
	wire homing_open;
	wire stack_full;
	wire stack_grow;
	wire stack_shrink;
	wire hit_fuse;
	wire hit_label;
	wire hit_line;
	wire hit_reg_index;
	wire hit_stack;
	wire hit_param_a;
	wire hit_param_b;
	wire hit_bus_timeout;
	wire hit_dup_node;
	wire hit_switch_leave;
	wire hit_multi_index;
	wire hit_single_index;
	wire hit_sync;
	wire hit_meas_limit;
	wire hit_ref_limit;
	wire hit_move;
	wire hit_power_on;
	wire hit_homing;
	wire hit_framing;
	wire hit_overrun;
	wire hit_checksum;
	wire record_code;

	function outside;
		input signed [POS_WIDTH-1:0] pos;
		input signed [POS_WIDTH-1:0] low;
		input signed [POS_WIDTH-1:0] high;
		begin
			outside = (pos < low) || (pos > high);
		end
	endfunction

	// Register decode is shared by the read mux and every write port.
	function reg_hit;
		input [3:0] adr;
		input [3:0] offset;
		begin
			reg_hit = (adr == offset);
		end
	endfunction

	assign bus_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
	assign wr_req = bus_req && wb_we_in;
	assign rd_req = bus_req && !wb_we_in;
	assign sel_code = reg_hit(wb_adr_in, `REG_ERROR_CODE);
	assign sel_ctrl = reg_hit(wb_adr_in, `REG_CHECK_CTRL);
	assign sel_low = reg_hit(wb_adr_in, `REG_LIMIT_LOW);
	assign sel_high = reg_hit(wb_adr_in, `REG_LIMIT_HIGH);
	// Any write to the code register clears it; data is ignored.
	assign clear_code = wr_req && sel_code;

	// Limits ignore byte lanes, so software must always write them as whole words.
	assign wr_bus_opt = wr_req && sel_ctrl && wb_sel_in[0];
	assign wr_limit_ctrl = wr_req && sel_ctrl && wb_sel_in[1];
	assign wr_low = wr_req && sel_low;
	assign wr_high = wr_req && sel_high;
	assign ctrl_lane0 = wb_dat_in[`CTRL_BUS_OPT_LSB +: 8];
	assign ctrl_lane1 = wb_dat_in[`CTRL_LIMIT_LSB +: 8];

	// An end stop may be met long before the other, so each is remembered until homing ends.
	assign stop_now = {end_stop_detect_b_in, end_stop_detect_a_in};
	assign homing_open = homing_active_in && !homing_done_in;

	genvar s;
	generate
		for (s = 0; s < 2; s = s + 1) begin : stop_track
			always @(posedge clk_in) begin
				if (rst_in || !homing_open) begin
					stop_seen[s] <= 1'b0;
				end else if (stop_now[s]) begin
					stop_seen[s] <= 1'b1;
				end
			end
		end
	endgenerate

	assign both_stops = (stop_seen[0] || stop_now[0]) && (stop_seen[1] || stop_now[1]);

	assign hit_fuse = fuse_blown_in;
	assign hit_label = jump_valid_in && (jump_label_in > {6'h00, `LABEL_MAX});
	assign hit_line = line_exec_in && (line_number_in > {3'h0, `LINE_MAX});
	assign hit_reg_index = reg_access_in && (reg_index_in > reg_index_max_in);
	// Push and pop in one cycle leave the level alone.
	assign stack_full = (stack_level_out == STACK_DEPTH[8:0]);
	assign stack_grow = stack_push_in && !stack_pop_in;
	assign stack_shrink = stack_pop_in && !stack_push_in;
	assign hit_stack = stack_grow && stack_full;
	assign hit_param_a = checked_param_a_bad_in;
	assign hit_param_b = checked_param_b_bad_in;
	// The timeout input is ignored unless software arms it through the bus option byte.
	assign hit_bus_timeout = bus_timeout_in && bus_option_param[`BUS_OPT_TIMEOUT_BIT];
	assign hit_dup_node = dup_node_in;
	assign hit_switch_leave = homing_active_in && switch_leave_done_in && home_switch_in;
	assign hit_multi_index = homing_open && both_stops && multi_index_setting_in;
	assign hit_single_index = homing_open && both_stops && !multi_index_setting_in;
	assign hit_sync = start_on_input_sync_fail_in;
	assign hit_meas_limit = position_valid_in && limit_check_control[`LIMIT_CHK_MEAS_BIT] &&
		outside(measured_position_in, position_limit_low, position_limit_high);
	assign hit_ref_limit = position_valid_in && limit_check_control[`LIMIT_CHK_REF_BIT] &&
		outside(reference_position_in, position_limit_low, position_limit_high);
	assign hit_move = move_req_in && !power_stage_enable_in;
	assign hit_power_on = power_on_req_in && interpolation_mode_in;
	assign hit_homing = homing_req_in && !homing_allowed_in;
	assign hit_framing = link_framing_err_in;
	assign hit_overrun = link_overrun_err_in;
	assign hit_checksum = link_checksum_err_in;

	// Lower code wins when several errors arise in one cycle.
	always @* begin
		next_code = 8'h00;
		if (hit_fuse) begin
			next_code = `ERR_FUSE;
		end else if (hit_label) begin
			next_code = `ERR_LABEL;
		end else if (hit_line) begin
			next_code = `ERR_LINE;
		end else if (hit_reg_index) begin
			next_code = `ERR_REG_INDEX;
		end else if (hit_stack) begin
			next_code = `ERR_STACK;
		end else if (hit_param_a) begin
			next_code = `ERR_PARAM_A;
		end else if (hit_param_b) begin
			next_code = `ERR_PARAM_B;
		end else if (hit_bus_timeout) begin
			next_code = `ERR_BUS_TIMEOUT;
		end else if (hit_dup_node) begin
			next_code = `ERR_DUP_NODE;
		end else if (hit_switch_leave) begin
			next_code = `ERR_SWITCH_LEAVE;
		end else if (hit_multi_index) begin
			next_code = `ERR_MULTI_INDEX;
		end else if (hit_single_index) begin
			next_code = `ERR_SINGLE_INDEX;
		end else if (hit_sync) begin
			next_code = `ERR_SYNC;
		end else if (hit_meas_limit) begin
			next_code = `ERR_MEAS_LIMIT;
		end else if (hit_ref_limit) begin
			next_code = `ERR_REF_LIMIT;
		end else if (hit_move) begin
			next_code = `ERR_MOVE_NO_POWER;
		end else if (hit_power_on) begin
			next_code = `ERR_POWER_IN_ITP;
		end else if (hit_homing) begin
			next_code = `ERR_HOMING;
		end else if (hit_framing) begin
			next_code = `ERR_FRAMING;
		end else if (hit_overrun) begin
			next_code = `ERR_OVERRUN;
		end else if (hit_checksum) begin
			next_code = `ERR_CHECKSUM;
		end
	end

	// A new error in the clearing cycle is still recorded, so set wins over clear.
	assign record_code = (next_code != 8'h00) && ((error_code_value_out == 8'h00) || clear_code);

	always @(posedge clk_in) begin
		if (rst_in) begin
			error_code_value_out <= `ERROR_CODE_RESET;
		end else if (record_code) begin
			error_code_value_out <= next_code;
		end else if (clear_code) begin
			error_code_value_out <= 8'h00;
		end
	end

	// Overflowing push is dropped so the level never exceeds the depth.
	always @* begin
		next_stack_level = stack_level_out;
		if (stack_grow && !stack_full) begin
			next_stack_level = stack_level_out + 9'h001;
		end else if (stack_shrink && stack_level_out != 9'h000) begin
			next_stack_level = stack_level_out - 9'h001;
		end
	end

	always @(posedge clk_in) begin
		if (rst_in) begin
			stack_level_out <= 9'h000;
		end else begin
			stack_level_out <= next_stack_level;
		end
	end

	// Refusal flags are registered so each output comes straight from a flip-flop.
	always @(posedge clk_in) begin
		if (rst_in) begin
			move_refused_out <= 1'b0;
			power_on_refused_out <= 1'b0;
			homing_refused_out <= 1'b0;
		end else begin
			move_refused_out <= hit_move;
			power_on_refused_out <= hit_power_on;
			homing_refused_out <= hit_homing;
		end
	end

	// Unmapped reads return zero rather than stale data.
	always @* begin
		next_rdata = 32'h00000000;
		if (rd_req) begin
			if (sel_code) begin
				next_rdata = {24'h000000, error_code_value_out};
			end else if (sel_ctrl) begin
				next_rdata = {16'h0000, limit_check_control, bus_option_param};
			end else if (sel_low) begin
				next_rdata = position_limit_low;
			end else if (sel_high) begin
				next_rdata = position_limit_high;
			end
		end
	end

	// Wishbone slave: one wait state, ack for one cycle.
	always @(posedge clk_in) begin
		if (rst_in) begin
			wb_ack_out <= 1'b0;
		end else begin
			wb_ack_out <= bus_req;
		end
	end

	// Read data is zero outside the ack cycle.
	always @(posedge clk_in) begin
		if (rst_in) begin
			wb_dat_out <= 32'h00000000;
		end else begin
			wb_dat_out <= next_rdata;
		end
	end

	always @(posedge clk_in) begin
		if (rst_in) begin
			bus_option_param <= `BUS_OPT_RESET;
		end else if (wr_bus_opt) begin
			bus_option_param <= ctrl_lane0;
		end
	end

	always @(posedge clk_in) begin
		if (rst_in) begin
			limit_check_control <= `LIMIT_CTRL_RESET;
		end else if (wr_limit_ctrl) begin
			limit_check_control <= ctrl_lane1;
		end
	end

	always @(posedge clk_in) begin
		if (rst_in) begin
			position_limit_low <= `LIMIT_LOW_RESET;
		end else if (wr_low) begin
			position_limit_low <= wb_dat_in;
		end
	end

	always @(posedge clk_in) begin
		if (rst_in) begin
			position_limit_high <= `LIMIT_HIGH_RESET;
		end else if (wr_high) begin
			position_limit_high <= wb_dat_in;
		end
	end

endmodule

`default_nettype wire

// [logic/error_code_monitor_map.vh]
`ifndef ERROR_CODE_MONITOR_MAP_VH
`define ERROR_CODE_MONITOR_MAP_VH

// Register byte offsets on the Wishbone bus.
`define REG_ERROR_CODE 4'h0
`define REG_CHECK_CTRL 4'h4
`define REG_LIMIT_LOW 4'h8
`define REG_LIMIT_HIGH 4'hC

// Field positions.
`define BUS_OPT_TIMEOUT_BIT 1
`define LIMIT_CHK_MEAS_BIT 1
`define LIMIT_CHK_REF_BIT 2
`define CTRL_BUS_OPT_LSB 0
`define CTRL_LIMIT_LSB 8

// Reset values.
`define ERROR_CODE_RESET 8'h00
`define BUS_OPT_RESET 8'h00
`define LIMIT_CTRL_RESET 8'h00
`define LIMIT_LOW_RESET 32'h80000000
`define LIMIT_HIGH_RESET 32'h7FFFFFFF

// Sequence and stack limits.
`define LABEL_MAX 10'h1FF
`define LINE_MAX 13'h1FFE
`define STACK_DEPTH 256

// Error codes.
`define ERR_FUSE 8'h23
`define ERR_LABEL 8'h24
`define ERR_LINE 8'h25
`define ERR_REG_INDEX 8'h26
`define ERR_STACK 8'h27
`define ERR_PARAM_A 8'h28
`define ERR_PARAM_B 8'h29
`define ERR_BUS_TIMEOUT 8'h38
`define ERR_DUP_NODE 8'h3B
`define ERR_SWITCH_LEAVE 8'h3C
`define ERR_MULTI_INDEX 8'h3D
`define ERR_SINGLE_INDEX 8'h3E
`define ERR_SYNC 8'h3F
`define ERR_MEAS_LIMIT 8'h41
`define ERR_REF_LIMIT 8'h42
`define ERR_MOVE_NO_POWER 8'h43
`define ERR_POWER_IN_ITP 8'h44
`define ERR_HOMING 8'h45
`define ERR_FRAMING 8'h50
`define ERR_OVERRUN 8'h51
`define ERR_CHECKSUM 8'h52

`endif

// [tb/error_code_monitor_sva.sv]
`timescale 1ns/1ns
`default_nettype none
module error_code_monitor_sva (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_ack_out,
	input wire logic fuse_blown_in,
	input wire logic link_framing_err_in,
	input wire logic move_req_in,
	input wire logic power_stage_enable_in,
	input wire logic move_refused_out,
	input wire logic power_on_req_in,
	input wire logic interpolation_mode_in,
	input wire logic power_on_refused_out,
	input wire logic homing_req_in,
	input wire logic homing_allowed_in,
	input wire logic homing_refused_out,
	input wire logic [7:0] error_code_value_out
);
	wire logic [7:0] c = error_code_value_out;
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	reset_clear_a: assert property (disable iff (1'b0) rst_in |=> c == 8'h00)
		else $error("code not cleared by reset");
	code_kept_a: assert property (c != 8'h00 && !wb_stb_in |=> $stable(c))
		else $error("recorded code changed");
	fuse_code_a: assert property (c == 8'h00 && fuse_blown_in |=> c == 8'h23)
		else $error("fuse code wrong");
	framing_code_a: assert property (c == 8'h00 && link_framing_err_in |=> c != 8'h00 && c <= 8'h50)
		else $error("framing code missing");
	move_refuse_a: assert property (move_req_in && !power_stage_enable_in |=> move_refused_out)
		else $error("move not refused");
	power_refuse_a: assert property (power_on_req_in && interpolation_mode_in |=> power_on_refused_out)
		else $error("power on not refused");
	homing_refuse_a: assert property (homing_req_in && !homing_allowed_in |=> homing_refused_out)
		else $error("homing not refused");
	ack_pulse_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out ##1 !wb_ack_out)
		else $error("bus ack not a single pulse");
	cover property (wb_ack_out);
	cover property (move_refused_out);
	cover property (c == 8'h52);
endmodule
bind error_code_monitor error_code_monitor_sva error_code_monitor_sva_inst (.*);
`default_nettype wire

// [tb/error_code_monitor_test.sv]
`timescale 1ns/1ns
`default_nettype none
module error_code_monitor_test;
	logic clk_in = 1'b0, rst_in = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, push = 1'b0, pop = 1'b0, ack, fr, ov, ck;
	logic [3:0] adr = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, dout;
	logic [20:0] src = 21'h0;
	logic [15:0] lbl = 16'h0, imax = 16'h10;
	logic signed [31:0] pos = 32'sh0;
	logic [7:0] code, prev = 8'h0;
	logic [8:0] level;
	logic [7:0] q[$];
	logic [7:0] codes[21] = '{8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h38, 8'h3B, 8'h3C, 8'h3D,
		8'h3E, 8'h3F, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h50, 8'h51, 8'h52};
	int failures = 0, num_checks = 0, cycles = 0;
	error_code_monitor error_code_monitor_inst (.clk_in(clk_in), .rst_in(rst_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
		.wb_we_in(we), .wb_adr_in(adr), .wb_sel_in({4{stb}}), .wb_dat_in(wdat), .wb_dat_out(dout), .wb_ack_out(ack),
		.fuse_blown_in(src[0]), .jump_valid_in(1'b1), .jump_label_in(src[1] ? 16'h200 : lbl), .line_exec_in(1'b1),
		.line_number_in(src[2] ? 16'h1FFF : 16'h1FFE), .reg_access_in(1'b1), .reg_index_in(src[3] ? imax + 16'h1 : imax),
		.reg_index_max_in(imax), .stack_push_in(push), .stack_pop_in(pop), .checked_param_a_bad_in(src[5]),
		.checked_param_b_bad_in(src[6]), .bus_timeout_in(src[7]), .dup_node_in(src[8]), .homing_active_in(|src[11:9]),
		.switch_leave_done_in(src[9]), .home_switch_in(src[9]), .multi_index_setting_in(src[10]),
		.end_stop_detect_a_in(|src[11:10]), .end_stop_detect_b_in(|src[11:10]), .homing_done_in(src[13]),
		.start_on_input_sync_fail_in(src[12]), .position_valid_in(1'b1), .measured_position_in(src[13] ? 32'sh65 : pos),
		.reference_position_in(src[14] ? -32'sh65 : pos), .move_req_in(src[15]), .power_stage_enable_in(~src[15]),
		.power_on_req_in(src[16]), .interpolation_mode_in(src[16]), .homing_req_in(src[17]), .homing_allowed_in(~src[17]),
		.link_framing_err_in(fr), .link_overrun_err_in(ov), .link_checksum_err_in(ck), .error_code_value_out(code),
		.move_refused_out(), .power_on_refused_out(), .homing_refused_out(), .stack_level_out(level));
	host_link_model host_link_model_inst (.clk_in(clk_in), .fault_in(src[20:18]), .framing_out(fr), .overrun_out(ov),
		.checksum_out(ck));
	initial begin
		forever #4 clk_in = ~clk_in;
	end
	task check(input string what, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask
	task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_in);
		{cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
		@(posedge clk_in);
		while (ack !== 1'b1) @(posedge clk_in);
		rdat = dout;
		{cyc, stb} <= 2'b00;
	endtask
	task settle(input logic [7:0] e);
		repeat (4) @(posedge clk_in);
		check("pending", 32'h0, 32'(q.size()));
		wb(1'b0, 4'h0, 32'h0);
		check("held", {24'h0, e}, rdat);
		wb(1'b1, 4'h0, 32'h0);
		wb(1'b0, 4'h0, 32'h0);
		check("cleared", 32'h0, rdat);
		$display("test %h done", e);
	endtask
	task fire(input logic [20:0] m, input logic [7:0] e);
		q.push_back(e);
		@(posedge clk_in);
		src <= m;
		lbl <= 16'($urandom % 512);
		imax <= 16'($urandom % 1000);
		pos <= 32'(int'($urandom % 201) - 100);
		@(posedge clk_in);
		src <= 21'h0;
		settle(e);
	endtask
	task span(input int lo, input int hi);
		for (int i = lo; i <= hi; i++) fire(21'h1 << i, codes[i]);
	endtask
	task finish_test;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Only a rise from zero is a new result; later changes are left to the checker.
	always @(posedge clk_in) begin
		if (!rst_in && prev === 8'h00 && code !== 8'h00) begin
			if (q.size() == 0) check("unexpected code", 32'h0, {24'h0, code});
			else check("code", {24'h0, q.pop_front()}, {24'h0, code});
		end
		prev <= code;
	end
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			failures++;
			finish_test;
		end
	end
	initial begin
		void'($urandom(32'h3d8c));
		repeat (8) @(posedge clk_in);
		rst_in <= 1'b0;
		wb(1'b0, 4'h0, 32'h0);
		check("code reset", 32'h0, rdat);
		wb(1'b0, 4'h2, 32'h0);
		check("unmapped", 32'h0, rdat);
		@(posedge clk_in);
		src <= 21'h80;
		@(posedge clk_in);
		src <= 21'h0;
		settle(8'h00);
		wb(1'b1, 4'h4, 32'h602);
		wb(1'b1, 4'h8, 32'hFFFFFF9C);
		wb(1'b1, 4'hC, 32'h64);
		span(0, 3);
		span(5, 12);
		span(13, 20);
		fire(21'h040001, 8'h23);
		fire(21'h1C0000, 8'h50);
		q.push_back(8'h27);
		push <= 1'b1;
		repeat (256) @(posedge clk_in);
		push <= 1'b0;
		@(posedge clk_in);
		check("full level", 32'h100, 32'(level));
		check("no early code", 32'h0, 32'(code));
		push <= 1'b1;
		@(posedge clk_in);
		push <= 1'b0;
		settle(8'h27);
		@(posedge clk_in);
		pop <= 1'b1;
		@(posedge clk_in);
		pop <= 1'b0;
		@(posedge clk_in);
		check("after pop", 32'hFF, 32'(level));
		finish_test;
	end
endmodule
`default_nettype wire

// [tb/host_link_model.sv]
`timescale 1ns/1ns
`default_nettype none
module host_link_model (
	input wire logic clk_in,
	input wire logic [2:0] fault_in,
	output logic framing_out = 1'b0,
	output logic overrun_out = 1'b0,
	output logic checksum_out = 1'b0
);
	// Faults leave a cycle late, so a fault raised with another source arrives after it.
	always @(posedge clk_in) begin
		{checksum_out, overrun_out, framing_out} <= fault_in;
	end
endmodule
`default_nettype wire
